// ---- design/sccs_pkg.sv ----
// Constants, encodings and state types of the system clock select and PLL control block.
// What this block does
// - Fast RC divide-by-N mode divides the RC clock by 1 up to 256.
// - Power-on source comes from the initial-source and primary-submode config fields.
// - Instruction clock and peripheral time base are the oscillator clock halved.
// - PLL input is divided by prescale N1, 2 through 33, from five-bit field.
// - PLL multiplies the VCO input by M from the nine-bit feedback field.
// - VCO output is divided by N2 of 2, 4 or 8 from two-bit field.
// - In PLL modes oscillator frequency is input times M over N1 times N2.
// - Source codes: RC, RC+PLL, primary, primary+PLL, secondary, LP RC, RC/16, RC/N.
// - Submode 10 high-speed crystal, 01 crystal, 00 external clock; others ignore it.
// - An erased device starts in fast RC divide-by-N mode.
// - Read-only bits 14..12 show the source in use.
// - Writable bits 10..8 hold the requested source, loaded from config at reset.
// - Lock-enable bit 7 with monitor config bit 1 freezes clock and PLL setup.
// - Bit 5 reads 1 when PLL locked or start-up timer done, else 0.
// - Bit 3 is set on clock failure, stays until software clears, resets 0.
// - Writes to the oscillator control register need an unlock sequence first.
// - Bits 15, 11, 6, 4 and 2 of the control register read zero.
// - Bit 0 starts a switch to the requested source; hardware clears it after.
// - Bit 1 enables the secondary low-power oscillator.
// - Postscale codes 00 /2, 01 /4 at reset, 11 /8, 10 reserved.
// - Prescale codes 00000 /2 at reset up to 11111 /33.
package sccs_pkg;

   // Bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte addresses.
   localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
   localparam logic [7:0] CLK_DIV_OFS = 8'h04;
   localparam logic [7:0] PLL_FBD_OFS = 8'h08;
   localparam logic [7:0] UNLOCK_OFS = 8'h0C;
   localparam logic [7:0] RATIO_OFS = 8'h10;

   // Unlock keys, written in this order to the unlock register.
   localparam logic [7:0] UNLOCK_KEY1 = 8'hA5;
   localparam logic [7:0] UNLOCK_KEY2 = 8'h5A;

   // Oscillator control field positions.
   localparam int CUR_LSB = 12;
   localparam int REQ_LSB = 8;
   localparam int LOCKEN_BIT = 7;
   localparam int PLLOK_BIT = 5;
   localparam int CF_BIT = 3;
   localparam int SECONDARY_OSC_BIT = 1;
   localparam int SWREQ_BIT = 0;

   // Clock divisor field positions.
   localparam int FAST_RC_POSTSCALE_SEL_LSB = 8;
   localparam int POST_LSB = 6;
   localparam int PRE_LSB = 0;

   // Ratio register field positions.
   localparam int RMUL_LSB = 16;
   localparam int RDIV_LSB = 0;

   // Reset values.
   localparam logic [2:0] FAST_RC_POSTSCALE_SEL_RST = 3'h0;
   localparam logic [1:0] POST_RST = 2'h1;
   localparam logic [4:0] PRE_RST = 5'h00;
   localparam logic [8:0] FBD_RST = 9'h030;

   // Source selection encoding.
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_SEC = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
   localparam logic [2:0] SRC_FRC_D16 = 3'h6;
   localparam logic [2:0] SRC_FRC_DN = 3'h7;

   // Primary submode encoding.
   localparam logic [1:0] SUB_EC = 2'h0;
   localparam logic [1:0] SUB_XT = 2'h1;
   localparam logic [1:0] SUB_HS = 2'h2;

   // Divider and multiplier offsets.
   localparam logic [5:0] PRE_BASE = 6'h02;
   localparam logic [9:0] FBD_BASE = 10'h002;
   localparam logic [8:0] DIV16 = 9'h010;

   // Timing: PLL start-up timer and source-change settle time.
   localparam int CLK_PERIOD_NS = 50;
   localparam int PLL_STARTUP_NS = 100000;
   localparam int PLL_STARTUP_CYC = (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_NS = 200;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Source switch sequence, Gray coded along its path.
   typedef enum logic [1:0] {
      SCCS_SW_IDLE = 2'b00,
      SCCS_SW_STOP = 2'b01,
      SCCS_SW_SWAP = 2'b11,
      SCCS_SW_START = 2'b10
   } sccs_sw_state_t;

endpackage : sccs_pkg

// ---- design/sccs_div_if.sv ----
// Interface between the clock control core and its tick divider.
`timescale 1ns/1ns
interface sccs_div_if;
   logic [8:0] ratio;
   logic run;
   logic tick;
   modport ctrl (output ratio, output run, input tick);
   modport div (input ratio, input run, output tick);
endinterface : sccs_div_if

// ---- design/sccs_divider.sv ----
// Programmable divider that turns the system clock into a one-cycle oscillator tick.
`timescale 1ns/1ns
module sccs_divider (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Ratio in, tick out.
   sccs_div_if.div dv
);
   typedef struct packed {
      logic [8:0] count;
      logic tick;
   } sccs_div_state_t;

   sccs_div_state_t s_q;
   sccs_div_state_t s_d;

   // Count to the ratio and pulse once per period; a stopped divider stays quiet.
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!dv.run) begin
         s_d.count = 9'h000;
      end else if (dv.ratio <= 9'h001 || s_q.count >= dv.ratio - 9'h001) begin
         s_d.count = 9'h000;
         s_d.tick = 1'b1;
      end else begin
         s_d.count = s_q.count + 9'h001;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dv.tick = s_q.tick;

endmodule : sccs_divider

// ---- design/sccs_top.sv ----
// System clock source selection, PLL ratio control and oscillator control registers.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
module sccs_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write channels.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Non-volatile configuration pins.
   input wire logic [2:0] initial_source_cfg,
   input wire logic [1:0] primary_submode_cfg,
   input wire logic clock_monitor_cfg_bit,
   // Analog PLL and fail-safe monitor.
   input wire logic pll_lock_in,
   input wire logic fail_detect,
   // Clock system outputs.
   output logic [2:0] current_source,
   output logic [1:0] primary_submode,
   output logic primary_osc_en,
   output logic secondary_osc_enable,
   output logic pll_enable,
   output logic switch_busy,
   output logic [9:0] fosc_mul,
   output logic [8:0] fosc_div,
   output logic osc_tick,
   output logic cycle_tick
);
   typedef struct packed {
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [2:0] cur;
      logic [2:0] req;
      logic lock_en;
      logic cf;
      logic secondary_osc_en;
      logic sw_req;
      logic [1:0] submode;
      logic [2:0] frc_sel;
      logic [1:0] post;
      logic [4:0] pre;
      logic [8:0] fbd;
      logic [1:0] unlock;
      sccs_pkg::sccs_sw_state_t sw;
      logic [2:0] settle;
      logic [11:0] pll_timer;
      logic pll_ok;
      logic phase;
      logic cyc_tick;
      logic [9:0] mul;
      logic [8:0] div;
      logic aw_have;
      logic [7:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sccs_top_state_t;

   sccs_top_state_t s_q;
   sccs_top_state_t s_d;
   sccs_div_if dif ();

   // Oscillator tick divider.
   sccs_divider u_div (
      .clk(clk),
      .rst(rst),
      .dv(dif)
   );

   // Fast RC postscale table, codes 0..7.
   function automatic logic [8:0] sccs_frc_ratio(input logic [2:0] code);
      logic [8:0] r;
      r = 9'h001 << code;
      if (code == 3'h7) begin
         r = 9'h100;
      end
      return r;
   endfunction : sccs_frc_ratio

   // Merge write data into a word under the byte strobes.
   function automatic logic [31:0] sccs_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : sccs_merge

   logic is_pll;
   logic frozen;
   logic [5:0] n1;
   logic [3:0] n2;
   logic [9:0] m_fac;
   logic [8:0] plain_div;
   logic [31:0] osc_word;
   logic [31:0] cdiv_word;
   logic [31:0] fbd_word;
   logic [31:0] ratio_word;

   // Derived factors and register images.
   always_comb begin
      n1 = sccs_pkg::PRE_BASE + {1'b0, s_q.pre};
      m_fac = sccs_pkg::FBD_BASE + {1'b0, s_q.fbd};
      case (s_q.post)
         2'h0: n2 = 4'h2;
         2'h3: n2 = 4'h8;
         default: n2 = 4'h4;
      endcase
      case (s_q.cur)
         sccs_pkg::SRC_FRC_D16: plain_div = sccs_pkg::DIV16;
         sccs_pkg::SRC_FRC_DN: plain_div = sccs_frc_ratio(s_q.frc_sel);
         default: plain_div = 9'h001;
      endcase
      is_pll = (s_q.cur == sccs_pkg::SRC_FRC_PLL) || (s_q.cur == sccs_pkg::SRC_PRI_PLL);
      // freeze when locked and monitor enabled
      frozen = s_q.lock_en && s_q.sync2[5];
      osc_word = '0;
      osc_word[sccs_pkg::CUR_LSB +: 3] = s_q.cur;
      osc_word[sccs_pkg::REQ_LSB +: 3] = s_q.req;
      osc_word[sccs_pkg::LOCKEN_BIT] = s_q.lock_en;
      osc_word[sccs_pkg::PLLOK_BIT] = s_q.pll_ok;
      osc_word[sccs_pkg::CF_BIT] = s_q.cf;
      osc_word[sccs_pkg::SECONDARY_OSC_BIT] = s_q.secondary_osc_en;
      osc_word[sccs_pkg::SWREQ_BIT] = s_q.sw_req;
      cdiv_word = '0;
      cdiv_word[sccs_pkg::FAST_RC_POSTSCALE_SEL_LSB +: 3] = s_q.frc_sel;
      cdiv_word[sccs_pkg::POST_LSB +: 2] = s_q.post;
      cdiv_word[sccs_pkg::PRE_LSB +: 5] = s_q.pre;
      fbd_word = {23'h000000, s_q.fbd};
      ratio_word = '0;
      ratio_word[sccs_pkg::RMUL_LSB +: 10] = s_q.mul;
      ratio_word[sccs_pkg::RDIV_LSB +: 9] = s_q.div;
   end

   logic wr_go;
   logic [31:0] wm;

   // Next-state logic for the whole block.
   always_comb begin
      s_d = s_q;
      wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      wm = 32'h00000000;
      // Config and PLL lock inputs pass two flops before use; fail_detect is used directly.
      s_d.sync1 = {pll_lock_in, clock_monitor_cfg_bit, primary_submode_cfg, initial_source_cfg};
      s_d.sync2 = s_q.sync1;

      // AXI address and data captured in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // Register write, once both halves are held.
      if (wr_go) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = sccs_pkg::RESP_OKAY;
         case (s_q.awaddr)
            sccs_pkg::OSC_CTRL_OFS: begin
               wm = sccs_merge(osc_word, s_q.wdata, s_q.wstrb);
               s_d.unlock = 2'h0;
               if (s_q.unlock == 2'h2) begin
                  s_d.lock_en = wm[sccs_pkg::LOCKEN_BIT];
                  s_d.secondary_osc_en = wm[sccs_pkg::SECONDARY_OSC_BIT];
                  if (!wm[sccs_pkg::CF_BIT]) begin
                     s_d.cf = 1'b0;
                  end
                  if (!frozen) begin
                     s_d.req = wm[sccs_pkg::REQ_LSB +: 3];
                     if (wm[sccs_pkg::SWREQ_BIT] && s_q.sw == sccs_pkg::SCCS_SW_IDLE) begin
                        s_d.sw_req = 1'b1;
                        s_d.sw = sccs_pkg::SCCS_SW_STOP;
                        s_d.settle = 3'(sccs_pkg::SETTLE_CYC);
                     end
                  end
               end
            end
            sccs_pkg::CLK_DIV_OFS: begin
               wm = sccs_merge(cdiv_word, s_q.wdata, s_q.wstrb);
               if (!frozen) begin
                  s_d.frc_sel = wm[sccs_pkg::FAST_RC_POSTSCALE_SEL_LSB +: 3];
                  s_d.post = wm[sccs_pkg::POST_LSB +: 2];
                  s_d.pre = wm[sccs_pkg::PRE_LSB +: 5];
               end
            end
            sccs_pkg::PLL_FBD_OFS: begin
               wm = sccs_merge(fbd_word, s_q.wdata, s_q.wstrb);
               if (!frozen) begin
                  s_d.fbd = wm[8:0];
               end
            end
            sccs_pkg::UNLOCK_OFS: begin
               if (s_q.wdata[7:0] == sccs_pkg::UNLOCK_KEY1) begin
                  s_d.unlock = 2'h1;
               end else if (s_q.wdata[7:0] == sccs_pkg::UNLOCK_KEY2 && s_q.unlock == 2'h1) begin
                  s_d.unlock = 2'h2;
               end else begin
                  s_d.unlock = 2'h0;
               end
            end
            sccs_pkg::RATIO_OFS: begin
               s_d.bresp = sccs_pkg::RESP_OKAY;
            end
            default: begin
               s_d.bresp = sccs_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Register read, answered one cycle after the address.
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = sccs_pkg::RESP_OKAY;
         case (s_axi_araddr)
            sccs_pkg::OSC_CTRL_OFS: s_d.rdata = osc_word;
            sccs_pkg::CLK_DIV_OFS: s_d.rdata = cdiv_word;
            sccs_pkg::PLL_FBD_OFS: s_d.rdata = fbd_word;
            sccs_pkg::UNLOCK_OFS: s_d.rdata = {30'h00000000, s_q.unlock};
            sccs_pkg::RATIO_OFS: s_d.rdata = ratio_word;
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = sccs_pkg::RESP_SLVERR;
            end
         endcase
      end

      // a failure sets the flag and wins over a clear
      if (fail_detect) begin
         s_d.cf = 1'b1;
      end

      // stop ticks, swap source, settle, then resume
      case (s_q.sw)
         sccs_pkg::SCCS_SW_IDLE: begin
            // Keep the settle count that a switch request has just loaded.
            if (s_d.sw == sccs_pkg::SCCS_SW_IDLE) begin
               s_d.settle = 3'h0;
            end
         end
         sccs_pkg::SCCS_SW_STOP: begin
            if (s_q.settle == 3'h0) begin
               s_d.sw = sccs_pkg::SCCS_SW_SWAP;
            end else begin
               s_d.settle = s_q.settle - 3'h1;
            end
         end
         sccs_pkg::SCCS_SW_SWAP: begin
            s_d.cur = s_q.req;
            s_d.pll_timer = 12'h000;
            s_d.settle = 3'(sccs_pkg::SETTLE_CYC);
            s_d.sw = sccs_pkg::SCCS_SW_START;
         end
         sccs_pkg::SCCS_SW_START: begin
            if (s_q.settle == 3'h0) begin
               s_d.sw_req = 1'b0;
               s_d.sw = sccs_pkg::SCCS_SW_IDLE;
            end else begin
               s_d.settle = s_q.settle - 3'h1;
            end
         end
         default: begin
            s_d.sw = sccs_pkg::SCCS_SW_IDLE;
         end
      endcase

      // lock status from the PLL or its start-up timer
      if (!is_pll || s_q.sw != sccs_pkg::SCCS_SW_IDLE) begin
         s_d.pll_ok = 1'b0;
         if (!is_pll) begin
            s_d.pll_timer = 12'h000;
         end
      end else begin
         if (s_q.pll_timer != 12'(sccs_pkg::PLL_STARTUP_CYC)) begin
            s_d.pll_timer = s_q.pll_timer + 12'h001;
         end
         s_d.pll_ok = s_q.sync2[6] || (s_q.pll_timer == 12'(sccs_pkg::PLL_STARTUP_CYC));
      end

      // oscillator ratio, M over N1 times N2 in PLL modes
      if (is_pll) begin
         s_d.mul = m_fac;
         s_d.div = 9'(n1) * 9'(n2);
      end else begin
         s_d.mul = 10'h001;
         s_d.div = plain_div;
      end

      // instruction tick is every second oscillator tick
      s_d.cyc_tick = 1'b0;
      if (dif.tick) begin
         s_d.phase = !s_q.phase;
         s_d.cyc_tick = s_q.phase;
      end

      // power-on source and submode from the config pins
      if (rst) begin
         s_d = '0;
         s_d.sync1 = {pll_lock_in, clock_monitor_cfg_bit, primary_submode_cfg, initial_source_cfg};
         s_d.sync2 = s_q.sync1;
         s_d.cur = s_q.sync2[2:0];
         s_d.req = s_q.sync2[2:0];
         s_d.submode = s_q.sync2[4:3];
         s_d.frc_sel = sccs_pkg::FAST_RC_POSTSCALE_SEL_RST;
         s_d.post = sccs_pkg::POST_RST;
         s_d.pre = sccs_pkg::PRE_RST;
         s_d.fbd = sccs_pkg::FBD_RST;
         s_d.sw = sccs_pkg::SCCS_SW_IDLE;
         s_d.mul = 10'h001;
         s_d.div = 9'h001;
      end
   end

   // Single state register; reset is folded into the next-state logic.
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   // divider runs only outside the source swap window
   assign dif.run = (s_q.sw == sccs_pkg::SCCS_SW_IDLE);
   assign dif.ratio = is_pll ? 9'h001 : plain_div;

   // Bus handshakes and answers.
   assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   // Clock system outputs; submode only matters for primary sources.
   assign current_source = s_q.cur;
   assign primary_submode = s_q.submode;
   assign primary_osc_en = (s_q.cur == sccs_pkg::SRC_PRI) || (s_q.cur == sccs_pkg::SRC_PRI_PLL);
   assign secondary_osc_enable = s_q.secondary_osc_en;
   assign pll_enable = is_pll;
   assign switch_busy = s_q.sw_req;
   assign fosc_mul = s_q.mul;
   assign fosc_div = s_q.div;
   assign osc_tick = dif.tick;
   assign cycle_tick = s_q.cyc_tick;

endmodule : sccs_top

// ---- sim/sccs_osc_model.sv ----
// Behavioural PLL loop and fail-safe monitor beside the clock control block.
`timescale 1ns/1ns
module sccs_osc_model #(parameter int LOCK_CYC = 16) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Requests from the block and the bench.
   input wire logic pll_enable,
   input wire logic fail_cmd,
   // Status towards the block.
   output logic pll_lock_in,
   output logic fail_detect
);
   int cnt_q = 0;
   logic fail_q = 1'b0;
   assign pll_lock_in = (cnt_q == LOCK_CYC);
   assign fail_detect = fail_q;
   // The loop only reports lock after running enabled for a while.
   always @(posedge clk) begin
      if (rst || !pll_enable) cnt_q <= 0;
      else if (cnt_q < LOCK_CYC) cnt_q <= cnt_q + 1;
      fail_q <= fail_cmd && !rst;
   end
endmodule : sccs_osc_model

// ---- sim/sccs_properties.sv ----
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/1ns
module sccs_properties (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register bus.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock system.
   input wire logic [2:0] current_source,
   input wire logic switch_busy,
   input wire logic pll_enable,
   input wire logic [9:0] fosc_mul,
   input wire logic [8:0] fosc_div,
   input wire logic osc_tick,
   input wire logic cycle_tick
);
   logic [7:0] ra_q;
   logic rst_q;
   default clocking cb @(posedge clk); endclocking
   // Checks also rest one cycle after reset, while sampled values still hold reset data.
   default disable iff (rst || rst_q);
   // Remembers the address of the read under way and the reset of the last cycle.
   always_ff @(posedge clk) begin
      rst_q <= rst;
      if (rst) ra_q <= 8'hFF;
      else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_held_idle;
      !switch_busy ##1 !switch_busy;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data moved");
   a_unused_zero: assert property (s_axi_rvalid && ra_q == 8'h00 |->
      s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[11] && !s_axi_rdata[6]
      && !s_axi_rdata[4] && !s_axi_rdata[2]) else $error("unused bit set");
   a_cycle_half: assert property (cycle_tick |-> $past(osc_tick))
      else $error("cycle tick without osc tick");
   a_tick_quiet: assert property (switch_busy ##1 switch_busy |-> !osc_tick)
      else $error("tick during switch");
   a_switch_span: assert property ($rose(switch_busy) |-> switch_busy [*8])
      else $error("switch too short");
   a_source_hold: assert property (s_held_idle |-> $stable(current_source))
      else $error("source moved while idle");
   a_pll_source: assert property (!switch_busy |-> pll_enable ==
      (current_source == 3'h1 || current_source == 3'h3) && (pll_enable || fosc_mul == 10'h001))
      else $error("pll enable wrong");
   a_div16_ratio: assert property (current_source == 3'h6 ##1 current_source == 3'h6
      |-> fosc_div == 9'h010 && fosc_mul == 10'h001) else $error("div16 ratio wrong");
endmodule : sccs_properties

// ---- sim/tb_top.sv ----
// Register level bench for the clock control block.
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, fail_cmd = 1'b0;
   logic rrdy = 1'b0, mon = 1'b1;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat;
   logic awr, wr_rdy, bv, arr, rv, sec_en, pll_en, busy, pll_lock, fail_det;
   logic [1:0] bresp, rresp, psub;
   logic [2:0] cur;
   int err_count = 0, checked = 0;
   localparam logic [7:0] A_OSC = 8'h00, A_DIV = 8'h04, A_FBD = 8'h08, A_RAT = 8'h10;
   // The clock toggles every 25 ns, half of the 50 ns period.
   always #25 clk = ~clk;
   sccs_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .initial_source_cfg(3'h7), .primary_submode_cfg(2'h2), .clock_monitor_cfg_bit(mon),
      .pll_lock_in(pll_lock), .fail_detect(fail_det), .current_source(cur),
      .primary_submode(psub), .primary_osc_en(), .secondary_osc_enable(sec_en),
      .pll_enable(pll_en), .switch_busy(busy), .fosc_mul(), .fosc_div(),
      .osc_tick(), .cycle_tick());
   sccs_osc_model osc (.clk(clk), .rst(rst), .pll_enable(pll_en), .fail_cmd(fail_cmd),
      .pll_lock_in(pll_lock), .fail_detect(fail_det));
   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One write; address and data are released as each is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clk);
         if (!ta && awr) begin
            ta = 1'b1;
            awv <= 1'b0;
         end
         if (!tw && wr_rdy) begin
            tw = 1'b1;
            wv <= 1'b0;
         end
      end while (!(ta && tw));
      do @(posedge clk); while (bv !== 1'b1);
   endtask : wr
   // One read, compared with the expected data and response.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      // Holds rready low for one cycle so that the answer must stand.
      @(posedge clk);
      rrdy <= 1'b1;
      do @(posedge clk); while (rv !== 1'b1);
      rrdy <= 1'b0;
      chk(rdat, e);
      chk({30'h0, rresp}, {30'h0, r});
   endtask : rd
   // The two key writes that open the control register.
   task automatic unlock();
      wr(8'h0C, {24'h0, sccs_pkg::UNLOCK_KEY1});
      wr(8'h0C, {24'h0, sccs_pkg::UNLOCK_KEY2});
   endtask : unlock
   // Waits for a requested source change to finish.
   task automatic wsw();
      repeat (2) @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      do @(posedge clk); while (busy !== 1'b0);
   endtask : wsw
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // Stops a hung run.
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done();
   end
   // Main sequence.
   initial begin
      logic [15:0] dv [3];
      logic [8:0] nn [3];
      dv = '{16'h00C3, 16'h001F, 16'h005F};
      nn = '{9'h028, 9'h042, 9'h084};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(A_OSC, 32'h7700, 2'h0);
      chk({30'h0, psub}, 32'h2);
      rd(A_DIV, 32'h0040, 2'h0);
      rd(A_FBD, 32'h0030, 2'h0);
      rd(A_RAT, 32'h00010001, 2'h0);
      wr(A_DIV, 32'h0740);
      rd(A_RAT, 32'h00010100, 2'h0);
      wr(A_DIV, 32'h0040);
      rd(8'h20, 32'h0, 2'h2);
      wr(A_OSC, 32'h0101);
      rd(A_OSC, 32'h7700, 2'h0);
      $display("reset and access tests done");
      // reach the PLL from the plain divide-by-N source, then step its ratios
      unlock();
      wr(A_OSC, 32'h0103);
      wsw();
      chk({31'h0, sec_en}, 32'h1);
      repeat (40) @(posedge clk);
      rd(A_OSC, 32'h1122, 2'h0);
      rd(A_RAT, 32'h00320008, 2'h0);
      wr(A_FBD, 32'h001E);
      for (int i = 0; i < 3; i++) begin
         wr(A_DIV, {16'h0, dv[i]});
         rd(A_RAT, {6'h0, 10'h020, 7'h0, nn[i]}, 2'h0);
      end
      wr(A_FBD, 32'h01FF);
      rd(A_RAT, {6'h0, 10'h201, 7'h0, 9'h084}, 2'h0);
      $display("pll tests done");
      unlock();
      wr(A_OSC, 32'h0601);
      wsw();
      rd(A_OSC, 32'h6600, 2'h0);
      fail_cmd <= 1'b1;
      @(posedge clk);
      fail_cmd <= 1'b0;
      repeat (3) @(posedge clk);
      wr(A_OSC, 32'h0600);
      rd(A_OSC, 32'h6608, 2'h0);
      unlock();
      wr(A_OSC, 32'h0600);
      rd(A_OSC, 32'h6600, 2'h0);
      $display("fail flag tests done");
      unlock();
      wr(A_OSC, 32'h0680);
      wr(A_DIV, 32'h0000);
      rd(A_DIV, 32'h005F, 2'h0);
      unlock();
      wr(A_OSC, 32'h0081);
      rd(A_OSC, 32'h6680, 2'h0);
      mon <= 1'b0;
      repeat (3) @(posedge clk);
      wr(A_DIV, 32'h0000);
      rd(A_DIV, 32'h0000, 2'h0);
      $display("lock tests done");
      test_done();
   end
endmodule : tb_top
bind sccs_top sccs_properties u_props (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .current_source,
   .switch_busy, .pll_enable, .fosc_mul, .fosc_div, .osc_tick, .cycle_tick);
